// ===== clock_gen_defs.vh
/*
 * Constants for the clock generator control block: register offsets, field
 * positions, reset values and internal codes.
 * Assumes it is included by bare name from the design file.
 */
`ifndef CLOCK_GEN_DEFS_VH
`define CLOCK_GEN_DEFS_VH

// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define OFS_PLL_MULTIPLIER 8'h38
`define OFS_PLL_REFERENCE_DIVIDER 8'h39
`define OFS_CLOCKGEN_TEST 8'h3A
`define OFS_SYNTH_EVENT_FLAGS 8'h3B
`define OFS_SYNTH_CONTROL 8'h3C
`define OFS_CLOCK_SOURCE_SELECT 8'h3D
`define OFS_LOW_RATE_DIVIDER 8'h3E

// ----------------------------------------------------------------------------
// Event flag register fields
// ----------------------------------------------------------------------------
`define FLG_LOCK_CHANGE 7
`define FLG_LOCK_STATUS 6
`define FLG_LIMP_CHANGE 1
`define FLG_LIMP_STATUS 0

// ----------------------------------------------------------------------------
// Synthesizer control register fields
// ----------------------------------------------------------------------------
`define CR_LOCK_IE 7
`define CR_POWER_ON 6
`define CR_AUTO_BW 5
`define CR_TRACKING 4
`define CR_KEEPALIVE 2
`define CR_LIMP_IE 1
`define CR_LIMP_DISABLE 0

// ----------------------------------------------------------------------------
// Clock source select register fields
// ----------------------------------------------------------------------------
`define SEL_SYNTH 7
`define SEL_LOWRATE 6
`define SEL_MODULE 0

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define RST_LOOP_DIV 6'h00
`define RST_REF_DIV 4'h0
`define RST_SLOW 6'h00
`define RST_AUTO_BW 1'h1

// ----------------------------------------------------------------------------
// Core clock source codes and switch hold time
// ----------------------------------------------------------------------------
`define SRC_XTAL 2'h0
`define SRC_LOWRATE 2'h1
`define SRC_SYNTH 2'h2
`define SWITCH_HOLD_CYCLES 4'h4

// ----------------------------------------------------------------------------
// Synchroniser bit positions
// ----------------------------------------------------------------------------
`define SY_LOCK 0
`define SY_NEAR 1
`define SY_REF_LOST 2
`define SY_SUPPLY 3

`endif

// ===== clock_gen_ctrl.v
/*
 * Clock generator control: synthesizer and divider registers, lock and
 * limp-home flags, clock source selection and derived clock enables.
 * Assumes clk is the crystal clock; the analog synthesizer supplies a
 * one-cycle tick per VCO period on synth_vco_tick in the clk domain, and the
 * lock, near-target, reference-lost and supply levels arrive asynchronously.
 */
`timescale 1ns/1ps
`include "clock_gen_defs.vh"

module clock_gen_ctrl #(
	parameter LOOP_W = 6,
	parameter REF_W = 4,
	parameter SLOW_W = 6
) (
	input wire clk,
	input wire rst,
	input wire [7:0] addr,
	input wire [7:0] wdata,
	input wire wr,
	input wire rd,
	output reg [7:0] rdata,
	input wire test_mode,
	input wire special_mode,
	input wire stop_req,
	input wire synth_vco_tick,
	input wire synth_in_lock,
	input wire synth_near_target,
	input wire ref_clk_lost,
	input wire synth_supply_level,
	output reg [LOOP_W-1:0] loop_divider_value,
	output reg [REF_W-1:0] reference_divider_value,
	output reg synth_power,
	output reg synth_low_bw,
	output reg osc_run,
	output reg cm_reset_req,
	output reg irq,
	output reg core_clk_en,
	output reg per_clk_en,
	output reg ext_bus_clk_en,
	output reg timebase_clk_en,
	output reg debug_clk_en,
	output reg module_clk_en,
	output reg low_rate_clk,
	output reg low_rate_clk_en,
	output reg cpu_hold
);

// ----------------------------------------------------------------------------
// Input synchronisers
// ----------------------------------------------------------------------------
reg [3:0] sync1_ff;
reg [3:0] sync2_ff;

always @(posedge clk) begin
	sync1_ff <= {synth_supply_level, ref_clk_lost, synth_near_target, synth_in_lock};
	sync2_ff <= sync1_ff;
end

wire lock_s = sync2_ff[`SY_LOCK];
wire near_s = sync2_ff[`SY_NEAR];
wire ref_lost_s = sync2_ff[`SY_REF_LOST];
wire supply_s = sync2_ff[`SY_SUPPLY];

// ----------------------------------------------------------------------------
// Register state
// ----------------------------------------------------------------------------
reg [LOOP_W-1:0] loop_div_ff;
reg [REF_W-1:0] ref_div_ff;
reg [SLOW_W-1:0] slow_ff;
reg lock_chg_ff;
reg limp_chg_ff;
reg lock_ie_ff;
reg limp_ie_ff;
reg pwr_on_ff;
reg auto_bw_ff;
reg tracking_ff;
reg keepalive_ff;
reg limp_dis_ff;
reg limp_dis_written_ff;
reg synth_sel_ff;
reg lowrate_sel_ff;
reg module_sel_ff;
reg lock_st_ff;
reg limp_st_ff;

// Limp-home and lock status as seen this cycle
wire limp_now = ref_lost_s & ~limp_dis_ff;
wire pwr_eff = pwr_on_ff | limp_now;
wire lock_now = lock_s & pwr_eff & ~limp_now;
wire synth_sel_eff = synth_sel_ff | limp_now;
wire module_sel_eff = module_sel_ff & ~limp_now;
wire tracking_now = auto_bw_ff ? (near_s & pwr_eff) : tracking_ff;

wire wr_mul = wr & (addr == `OFS_PLL_MULTIPLIER);
wire wr_ref = wr & (addr == `OFS_PLL_REFERENCE_DIVIDER);
wire wr_flg = wr & (addr == `OFS_SYNTH_EVENT_FLAGS);
wire wr_ctl = wr & (addr == `OFS_SYNTH_CONTROL);
wire wr_sel = wr & (addr == `OFS_CLOCK_SOURCE_SELECT);
wire wr_slow = wr & (addr == `OFS_LOW_RATE_DIVIDER);

wire lock_toggle = lock_now ^ lock_st_ff;
wire limp_toggle = limp_now ^ limp_st_ff;

// ----------------------------------------------------------------------------
// Register writes
// ----------------------------------------------------------------------------
always @(posedge clk) begin
	if (rst) begin
		loop_div_ff <= `RST_LOOP_DIV;
		ref_div_ff <= `RST_REF_DIV;
		slow_ff <= `RST_SLOW;
		lock_chg_ff <= 1'b0;
		limp_chg_ff <= 1'b0;
		lock_ie_ff <= 1'b0;
		limp_ie_ff <= 1'b0;
		pwr_on_ff <= 1'b1;
		auto_bw_ff <= `RST_AUTO_BW;
		tracking_ff <= 1'b0;
		keepalive_ff <= 1'b0;
		limp_dis_ff <= 1'b0;
		limp_dis_written_ff <= 1'b0;
		synth_sel_ff <= 1'b0;
		lowrate_sel_ff <= 1'b0;
		module_sel_ff <= 1'b0;
		lock_st_ff <= 1'b0;
		limp_st_ff <= 1'b0;
	end else begin
		lock_st_ff <= lock_now;
		limp_st_ff <= limp_now;
		if (wr_mul && !synth_sel_ff) begin
			loop_div_ff <= wdata[LOOP_W-1:0];
		end
		if (wr_ref && !synth_sel_ff) begin
			ref_div_ff <= wdata[REF_W-1:0];
		end
		if (wr_slow) begin
			slow_ff <= wdata[SLOW_W-1:0];
		end
		// Set wins over a simultaneous write-one clear
		if (limp_now) begin
			lock_chg_ff <= 1'b0;
		end else if (lock_toggle) begin
			lock_chg_ff <= 1'b1;
		end else if (wr_flg && wdata[`FLG_LOCK_CHANGE]) begin
			lock_chg_ff <= 1'b0;
		end
		if (limp_toggle) begin
			limp_chg_ff <= 1'b1;
		end else if (wr_flg && wdata[`FLG_LIMP_CHANGE]) begin
			limp_chg_ff <= 1'b0;
		end
		if (wr_ctl) begin
			lock_ie_ff <= wdata[`CR_LOCK_IE];
			limp_ie_ff <= wdata[`CR_LIMP_IE];
			if (wdata[`CR_POWER_ON] || !synth_sel_ff) begin
				pwr_on_ff <= wdata[`CR_POWER_ON];
			end
			auto_bw_ff <= wdata[`CR_AUTO_BW];
			if (!auto_bw_ff) begin
				tracking_ff <= wdata[`CR_TRACKING];
			end
			keepalive_ff <= wdata[`CR_KEEPALIVE];
			if (special_mode || !limp_dis_written_ff) begin
				limp_dis_ff <= wdata[`CR_LIMP_DISABLE];
				limp_dis_written_ff <= 1'b1;
			end
		end
		if (wr_sel) begin
			if (!wdata[`SEL_SYNTH] || pwr_on_ff) begin
				synth_sel_ff <= wdata[`SEL_SYNTH];
			end
			lowrate_sel_ff <= wdata[`SEL_LOWRATE];
			module_sel_ff <= wdata[`SEL_MODULE];
		end
		// No synthesizer supply overrides the interrupt enables, power-on and limp-home disable written above
		if (!supply_s) begin
			lock_ie_ff <= 1'b0;
			limp_ie_ff <= 1'b0;
			pwr_on_ff <= 1'b0;
			limp_dis_ff <= 1'b1;
		end
	end
end

// ----------------------------------------------------------------------------
// Register reads
// ----------------------------------------------------------------------------
always @(posedge clk) begin
	if (rst) begin
		rdata <= 8'h00;
	end else if (rd) begin
		case (addr)
			`OFS_PLL_MULTIPLIER: rdata <= {{(8-LOOP_W){1'b0}}, loop_div_ff};
			`OFS_PLL_REFERENCE_DIVIDER: rdata <= {{(8-REF_W){1'b0}}, ref_div_ff};
			`OFS_CLOCKGEN_TEST: rdata <= test_mode ? {4'h0, sync2_ff} : 8'h00;
			`OFS_SYNTH_EVENT_FLAGS: rdata <= {lock_chg_ff, lock_st_ff, 4'h0, limp_chg_ff, limp_st_ff};
			`OFS_SYNTH_CONTROL: rdata <= {lock_ie_ff, pwr_on_ff, auto_bw_ff, tracking_now, 1'b0,
				keepalive_ff, limp_ie_ff, limp_dis_ff};
			`OFS_CLOCK_SOURCE_SELECT: rdata <= {synth_sel_ff, lowrate_sel_ff, 5'h00, module_sel_ff};
			`OFS_LOW_RATE_DIVIDER: rdata <= {{(8-SLOW_W){1'b0}}, slow_ff};
			default: rdata <= 8'h00;
		endcase
	end else begin
		rdata <= 8'h00;
	end
end

// ----------------------------------------------------------------------------
// Low-rate divider
// ----------------------------------------------------------------------------
reg [SLOW_W-1:0] lr_cnt_ff;
wire lr_bypass = (slow_ff == {SLOW_W{1'b0}});
wire lr_half_done = (lr_cnt_ff >= slow_ff - {{(SLOW_W-1){1'b0}}, 1'b1});
wire lr_tick = lr_bypass | (lr_half_done & ~low_rate_clk);

// A new value restarts the current half period, so it applies within one cycle
always @(posedge clk) begin
	if (rst) begin
		lr_cnt_ff <= {SLOW_W{1'b0}};
		low_rate_clk <= 1'b0;
		low_rate_clk_en <= 1'b0;
	end else begin
		low_rate_clk_en <= lr_tick;
		if (lr_bypass) begin
			lr_cnt_ff <= {SLOW_W{1'b0}};
			low_rate_clk <= ~low_rate_clk;
		end else if (wr_slow || lr_half_done) begin
			lr_cnt_ff <= {SLOW_W{1'b0}};
			if (!wr_slow) begin
				low_rate_clk <= ~low_rate_clk;
			end
		end else begin
			lr_cnt_ff <= lr_cnt_ff + {{(SLOW_W-1){1'b0}}, 1'b1};
		end
	end
end

// ----------------------------------------------------------------------------
// Core clock source and glitch-free switching
// ----------------------------------------------------------------------------
reg [1:0] cur_src_ff;
reg [3:0] sw_cnt_ff;
reg switching_ff;
reg [1:0] want_src;
reg src_tick;

always @* begin
	if (synth_sel_eff) begin
		want_src = `SRC_SYNTH;
	end else if (lowrate_sel_ff) begin
		want_src = `SRC_LOWRATE;
	end else begin
		want_src = `SRC_XTAL;
	end
	case (cur_src_ff)
		`SRC_SYNTH: src_tick = synth_vco_tick;
		`SRC_LOWRATE: src_tick = lr_tick;
		default: src_tick = 1'b1;
	endcase
end

wire core_tick = src_tick & ~switching_ff;

always @(posedge clk) begin
	if (rst) begin
		cur_src_ff <= `SRC_XTAL;
		sw_cnt_ff <= 4'h0;
		switching_ff <= 1'b0;
	end else if (switching_ff) begin
		if (sw_cnt_ff == `SWITCH_HOLD_CYCLES) begin
			switching_ff <= 1'b0;
			cur_src_ff <= want_src;
		end else begin
			sw_cnt_ff <= sw_cnt_ff + 4'h1;
		end
	end else if (want_src != cur_src_ff) begin
		switching_ff <= 1'b1;
		sw_cnt_ff <= 4'h0;
	end
end

// ----------------------------------------------------------------------------
// Divide-by-two chains and derived enables
// ----------------------------------------------------------------------------
reg core_div_ff;
reg syn_div_ff;
reg lr_div_ff;
reg xt_div_ff;

wire bus_tick = core_tick & core_div_ff;
wire syn_half = synth_vco_tick & syn_div_ff;
wire tb_tick = lr_tick & lr_div_ff;
wire xt_half = xt_div_ff;
wire core_slower = lowrate_sel_ff & ~synth_sel_ff & ~lr_bypass;

always @(posedge clk) begin
	if (rst) begin
		core_div_ff <= 1'b0;
		syn_div_ff <= 1'b0;
		lr_div_ff <= 1'b0;
		xt_div_ff <= 1'b0;
		core_clk_en <= 1'b0;
		per_clk_en <= 1'b0;
		ext_bus_clk_en <= 1'b0;
		timebase_clk_en <= 1'b0;
		debug_clk_en <= 1'b0;
		module_clk_en <= 1'b0;
		cpu_hold <= 1'b0;
	end else begin
		if (core_tick) begin
			core_div_ff <= ~core_div_ff;
		end
		if (synth_vco_tick) begin
			syn_div_ff <= ~syn_div_ff;
		end
		if (lr_tick) begin
			lr_div_ff <= ~lr_div_ff;
		end
		xt_div_ff <= ~xt_div_ff;
		core_clk_en <= core_tick;
		cpu_hold <= switching_ff;
		if (limp_now) begin
			// None of these five enables fires twice in a row, so a source change cannot leave a runt tick
			per_clk_en <= syn_half & ~per_clk_en;
			ext_bus_clk_en <= syn_half & ~ext_bus_clk_en;
			timebase_clk_en <= syn_half & ~timebase_clk_en;
			debug_clk_en <= syn_half & ~debug_clk_en;
			module_clk_en <= syn_half & ~module_clk_en;
		end else begin
			per_clk_en <= bus_tick & ~per_clk_en;
			ext_bus_clk_en <= bus_tick & ~ext_bus_clk_en;
			timebase_clk_en <= tb_tick & ~timebase_clk_en;
			debug_clk_en <= (core_slower ? bus_tick : xt_half) & ~debug_clk_en;
			module_clk_en <= (module_sel_eff ? tb_tick : bus_tick) & ~module_clk_en;
		end
	end
end

// ----------------------------------------------------------------------------
// Synthesizer controls, reset request and interrupt
// ----------------------------------------------------------------------------
always @(posedge clk) begin
	if (rst) begin
		loop_divider_value <= `RST_LOOP_DIV;
		reference_divider_value <= `RST_REF_DIV;
		synth_power <= 1'b0;
		synth_low_bw <= 1'b0;
		osc_run <= 1'b1;
		cm_reset_req <= 1'b0;
		irq <= 1'b0;
	end else begin
		loop_divider_value <= loop_div_ff;
		reference_divider_value <= ref_div_ff;
		synth_power <= pwr_eff;
		synth_low_bw <= tracking_now;
		osc_run <= ~stop_req | keepalive_ff;
		cm_reset_req <= ref_lost_s & limp_dis_ff;
		irq <= (lock_chg_ff & lock_ie_ff) | (limp_chg_ff & limp_ie_ff);
	end
end

endmodule

// ===== clock_gen_ctrl_props.sv
/* Concurrent checks on the clock generator control ports.
   Assumes it is bound into clock_gen_ctrl, one clock domain, rst synchronous. */
`timescale 1ns/1ps
module clock_gen_ctrl_props (
	input wire clk,
	input wire rst,
	input wire rd,
	input wire [7:0] rdata,
	input wire stop_req,
	input wire ref_clk_lost,
	input wire synth_supply_level,
	input wire synth_power,
	input wire osc_run,
	input wire cm_reset_req,
	input wire irq,
	input wire core_clk_en,
	input wire per_clk_en,
	input wire ext_bus_clk_en,
	input wire timebase_clk_en,
	input wire debug_clk_en,
	input wire low_rate_clk_en,
	input wire cpu_hold
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	// ------------------------------------------------------------
	// Assertions and cover points
	// ------------------------------------------------------------
	chk_rdata_quiet: assert property (!$past(rd) |-> rdata == 8'h00) else $error("rdata not idle");
	chk_per_spacing: assert property (per_clk_en |=> !per_clk_en) else $error("peripheral tick doubled");
	chk_ext_per_pair: assert property (ext_bus_clk_en == per_clk_en) else $error("bus and peripheral split");
	chk_debug_spacing: assert property (debug_clk_en |=> !debug_clk_en) else $error("debug tick doubled");
	chk_tb_spacing: assert property (timebase_clk_en |=> !timebase_clk_en) else $error("timebase doubled");
	chk_switch_stall: assert property (cpu_hold |-> !core_clk_en) else $error("core ticks in switch");
	chk_switch_len: assert property ($rose(cpu_hold) |-> cpu_hold[*4] ##[1:3] !cpu_hold) else $error("switch hold length");
	chk_cm_cause: assert property ((!ref_clk_lost)[*5] |-> !cm_reset_req) else $error("spurious monitor reset");
	chk_supply_irq: assert property ((!synth_supply_level)[*5] |-> !irq) else $error("irq without supply");
	chk_limp_power: assert property (ref_clk_lost[*6] |-> synth_power || cm_reset_req) else $error("limp power off");
	chk_osc_awake: assert property ((!stop_req)[*2] |-> osc_run) else $error("oscillator stopped");
	cov_switch: cover property ($rose(cpu_hold));
	cov_monitor: cover property ($rose(cm_reset_req));
	cov_irq: cover property ($rose(irq));
	cov_low_rate: cover property (low_rate_clk_en ##1 !low_rate_clk_en);
endmodule

bind clock_gen_ctrl clock_gen_ctrl_props u_props (.clk(clk), .rst(rst), .rd(rd), .rdata(rdata),
	.stop_req(stop_req), .ref_clk_lost(ref_clk_lost), .synth_supply_level(synth_supply_level),
	.synth_power(synth_power), .osc_run(osc_run), .cm_reset_req(cm_reset_req), .irq(irq),
	.core_clk_en(core_clk_en), .per_clk_en(per_clk_en), .ext_bus_clk_en(ext_bus_clk_en),
	.timebase_clk_en(timebase_clk_en), .debug_clk_en(debug_clk_en), .low_rate_clk_en(low_rate_clk_en),
	.cpu_hold(cpu_hold));

// ===== synth_model.sv
/* Behavioural frequency synthesizer: VCO tick every third cycle, near and lock levels after settling.
   Assumes the same clock as the control block; lose_lock lets the bench drop lock on purpose. */
`timescale 1ns/1ps
module synth_model #(
	parameter LOCK_DELAY = 30
) (
	input wire clk,
	input wire rst,
	input wire synth_power,
	input wire lose_lock,
	output reg vco_tick = 1'b0,
	output reg in_lock = 1'b0,
	output reg near_target = 1'b0
);
	reg [7:0] settle_ff = 8'h00;
	reg [1:0] phase_ff = 2'h0;
	always @(posedge clk) begin
		if (rst || !synth_power) begin
			settle_ff <= 8'h00;
			phase_ff <= 2'h0;
			vco_tick <= 1'b0;
			in_lock <= 1'b0;
			near_target <= 1'b0;
		end else begin
			phase_ff <= (phase_ff == 2'h2) ? 2'h0 : phase_ff + 2'h1;
			vco_tick <= (phase_ff == 2'h2);
			settle_ff <= (settle_ff == 8'hFF) ? settle_ff : settle_ff + 8'h01;
			near_target <= (settle_ff >= LOCK_DELAY / 2);
			in_lock <= (settle_ff >= LOCK_DELAY) && !lose_lock;
		end
	end
endmodule

// ===== clock_gen_ctrl_tb.sv
/* Self-checking bench for clock_gen_ctrl with the synthesizer model on its analog side.
   Assumes the checker and synth_model files are compiled first. */
`timescale 1ns/1ps
`define CHK(nm, e, g) begin total_checks = total_checks + 1; if ((e) !== (g)) begin \
	n_fail = n_fail + 1; $display("CHECK FAILED %s expected %0h seen %0h", nm, e, g); end end
module clock_gen_ctrl_tb;
	reg clk = 1'b0;
	reg rst = 1'b1;
	reg wr = 1'b0;
	reg rd = 1'b0;
	reg [7:0] addr = 8'h00;
	reg [7:0] wdata = 8'h00;
	reg test_mode = 1'b0;
	reg special_mode = 1'b0;
	reg stop_req = 1'b0;
	reg ref_clk_lost = 1'b0;
	reg synth_supply_level = 1'b1;
	reg lose_lock = 1'b0;
	wire [7:0] rdata;
	wire [5:0] loop_div;
	wire [3:0] ref_div;
	wire vco_tick, in_lock, near_target, synth_power, synth_low_bw, osc_run, cm_reset_req, irq;
	wire core_clk_en, per_clk_en, ext_bus_clk_en, timebase_clk_en, debug_clk_en, module_clk_en;
	wire low_rate_clk, low_rate_clk_en, cpu_hold;
	integer n_fail = 0;
	integer total_checks = 0;
	integer cnt [0:7];
	integer base [0:7];
	integer seen [0:7];
	clock_gen_ctrl u_clock_gen_ctrl (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
		.rdata(rdata), .test_mode(test_mode), .special_mode(special_mode), .stop_req(stop_req),
		.synth_vco_tick(vco_tick), .synth_in_lock(in_lock), .synth_near_target(near_target),
		.ref_clk_lost(ref_clk_lost), .synth_supply_level(synth_supply_level), .loop_divider_value(loop_div),
		.reference_divider_value(ref_div), .synth_power(synth_power), .synth_low_bw(synth_low_bw),
		.osc_run(osc_run), .cm_reset_req(cm_reset_req), .irq(irq), .core_clk_en(core_clk_en),
		.per_clk_en(per_clk_en), .ext_bus_clk_en(ext_bus_clk_en), .timebase_clk_en(timebase_clk_en),
		.debug_clk_en(debug_clk_en), .module_clk_en(module_clk_en), .low_rate_clk(low_rate_clk),
		.low_rate_clk_en(low_rate_clk_en), .cpu_hold(cpu_hold));
	synth_model u_synth_model (.clk(clk), .rst(rst), .synth_power(synth_power), .lose_lock(lose_lock),
		.vco_tick(vco_tick), .in_lock(in_lock), .near_target(near_target));
	// ------------------------------------------------------------
	// Clock, tick counters, bus tasks
	// ------------------------------------------------------------
	initial forever #2.5 clk = ~clk;
	initial for (int k = 0; k < 8; k++) cnt[k] = 0;
	always @(posedge clk) begin
		if (!rst) begin
			cnt[0] <= cnt[0] + per_clk_en;
			cnt[1] <= cnt[1] + module_clk_en;
			cnt[2] <= cnt[2] + timebase_clk_en;
			cnt[3] <= cnt[3] + low_rate_clk_en;
			cnt[4] <= cnt[4] + low_rate_clk;
			cnt[5] <= cnt[5] + core_clk_en;
			cnt[6] <= cnt[6] + debug_clk_en;
			cnt[7] <= cnt[7] + ext_bus_clk_en;
		end
	end
	task wr_reg(input [7:0] a, input [7:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task rd_chk(input [7:0] a, input [7:0] m, input [7:0] e);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		`CHK("rdata", e, rdata & m)
	endtask
	task wait_cyc(input integer n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task window(input integer n);
		for (int k = 0; k < 8; k++) base[k] = cnt[k];
		wait_cyc(n);
		for (int k = 0; k < 8; k++) seen[k] = cnt[k] - base[k];
	endtask
	task conclude;
		$display("checks %0d mismatches %0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	task t_reset;
		rd_chk(8'h3B, 8'hFF, 8'h00);
		rd_chk(8'h38, 8'hFF, 8'h00);
		rd_chk(8'h3C, 8'hFF, 8'h60);
		rd_chk(8'h3A, 8'hFF, 8'h00);
		rd_chk(8'h3D, 8'hFF, 8'h00);
		rd_chk(8'h3F, 8'hFF, 8'h00);
	endtask
	task t_dividers;
		wr_reg(8'h38, 8'h3F);
		wr_reg(8'h39, 8'h0F);
		wait_cyc(2);
		`CHK("loop_div", 6'h3F, loop_div)
		`CHK("ref_div", 4'hF, ref_div)
		wr_reg(8'h3D, 8'h80);
		wr_reg(8'h38, 8'h01);
		wr_reg(8'h39, 8'h00);
		rd_chk(8'h38, 8'hFF, 8'h3F);
		rd_chk(8'h39, 8'hFF, 8'h0F);
		wr_reg(8'h3C, 8'h00);
		rd_chk(8'h3C, 8'hFF, 8'h40);
		wr_reg(8'h3D, 8'h00);
		wr_reg(8'h3C, 8'h10);
		wait_cyc(3);
		`CHK("low_bw", 1'b1, synth_low_bw)
		`CHK("power", 1'b0, synth_power)
		wr_reg(8'h3C, 8'h00);
		wr_reg(8'h3D, 8'h80);
		wait_cyc(3);
		`CHK("low_bw", 1'b0, synth_low_bw)
		rd_chk(8'h3D, 8'hFF, 8'h00);
		wr_reg(8'h3C, 8'hE0);
	endtask
	task t_lock;
		wait_cyc(50);
		rd_chk(8'h3B, 8'hFF, 8'hC0);
		`CHK("irq", 1'b1, irq)
		rd_chk(8'h3C, 8'hFF, 8'hF0);
		`CHK("low_bw", 1'b1, synth_low_bw)
		@(posedge clk);
		test_mode <= 1'b1;
		rd_chk(8'h3A, 8'hFF, 8'h0B);
		@(posedge clk);
		test_mode <= 1'b0;
		wr_reg(8'h3B, 8'hC0);
		rd_chk(8'h3B, 8'hFF, 8'h40);
		`CHK("irq", 1'b0, irq)
		@(posedge clk);
		lose_lock <= 1'b1;
		wait_cyc(6);
		rd_chk(8'h3B, 8'hFF, 8'h80);
		`CHK("irq", 1'b1, irq)
		@(posedge clk);
		lose_lock <= 1'b0;
		wait_cyc(6);
		wr_reg(8'h3B, 8'h80);
	endtask
	task t_limp;
		wr_reg(8'h3C, 8'h62);
		@(posedge clk);
		ref_clk_lost <= 1'b1;
		wait_cyc(12);
		rd_chk(8'h3B, 8'hFF, 8'h03);
		`CHK("irq", 1'b1, irq)
		`CHK("power", 1'b1, synth_power)
		rd_chk(8'h3D, 8'hFF, 8'h00);
		window(60);
		`CHK("per_ticks", 10, seen[0])
		`CHK("module_ticks", 10, seen[1])
		`CHK("timebase_ticks", 10, seen[2])
		`CHK("ext_bus_ticks", 10, seen[7])
		`CHK("debug_ticks", 10, seen[6])
		wr_reg(8'h3B, 8'h02);
		rd_chk(8'h3B, 8'h03, 8'h01);
		@(posedge clk);
		ref_clk_lost <= 1'b0;
		wait_cyc(8);
		rd_chk(8'h3B, 8'h03, 8'h02);
		wr_reg(8'h3B, 8'h82);
	endtask
	task t_write_once;
		wr_reg(8'h3C, 8'h61);
		rd_chk(8'h3C, 8'h01, 8'h00);
		@(posedge clk);
		special_mode <= 1'b1;
		wr_reg(8'h3C, 8'h61);
		rd_chk(8'h3C, 8'h01, 8'h01);
		@(posedge clk);
		special_mode <= 1'b0;
		ref_clk_lost <= 1'b1;
		wait_cyc(8);
		`CHK("cm_reset", 1'b1, cm_reset_req)
		rd_chk(8'h3B, 8'h01, 8'h00);
		@(posedge clk);
		ref_clk_lost <= 1'b0;
		wait_cyc(8);
	endtask
	task t_slow;
		wr_reg(8'h3E, 8'h04);
		rd_chk(8'h3E, 8'hFF, 8'h04);
		window(80);
		`CHK("low_rate_ticks", 10, seen[3])
		`CHK("low_rate_high", 40, seen[4])
		wr_reg(8'h3D, 8'h41);
		wait_cyc(2);
		`CHK("cpu_hold", 1'b1, cpu_hold)
		wait_cyc(10);
		window(80);
		`CHK("core_ticks_slow", 10, seen[5])
		`CHK("module_ticks_slow", 5, seen[1])
		`CHK("debug_ticks_slow", 5, seen[6])
		`CHK("ext_bus_ticks_slow", 5, seen[7])
		wr_reg(8'h3D, 8'hC0);
		wait_cyc(12);
		window(60);
		`CHK("core_ticks_synth", 20, seen[5])
		wr_reg(8'h3D, 8'h00);
		wr_reg(8'h3E, 8'h00);
		wait_cyc(12);
		window(20);
		`CHK("low_rate_bypass", 20, seen[3])
		`CHK("debug_ticks_xtal", 10, seen[6])
		`CHK("per_ticks_xtal", 10, seen[0])
	endtask
	task t_stop_supply;
		@(posedge clk);
		stop_req <= 1'b1;
		wait_cyc(3);
		`CHK("osc_run", 1'b0, osc_run)
		wr_reg(8'h3C, 8'hE7);
		wait_cyc(2);
		`CHK("osc_run", 1'b1, osc_run)
		@(posedge clk);
		stop_req <= 1'b0;
		synth_supply_level <= 1'b0;
		wait_cyc(8);
		rd_chk(8'h3C, 8'hC3, 8'h01);
		`CHK("irq", 1'b0, irq)
		@(posedge clk);
		synth_supply_level <= 1'b1;
		wait_cyc(8);
	endtask
	initial begin
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		t_reset;
		t_dividers;
		t_lock;
		t_limp;
		t_write_once;
		t_slow;
		t_stop_supply;
		conclude;
	end
	initial begin
		repeat (5000) @(posedge clk);
		n_fail = n_fail + 1;
		conclude;
	end
endmodule
